// [hw/table_access_pkg.sv]
// table access unit constants: register indices, field layout, reset values, timing
// assumes a single 250 MHz core clock and a 32-bit register bus with word-aligned registers
package table_access_pkg;

    // ************************************************************
    // register map (printed offsets are register indices)
    // ************************************************************
    localparam logic [11:0] IDX_TABLE_LATCH = 12'hff5;
    localparam logic [11:0] IDX_POINTER_LOW = 12'hff6;
    localparam logic [11:0] IDX_POINTER_HIGH = 12'hff7;
    localparam logic [11:0] IDX_POINTER_UPPER = 12'hff8;
    localparam int BYTE_ADDR_SHIFT = 2; // byte address = index * 4

    // ************************************************************
    // pointer field layout
    // ************************************************************
    localparam int PTR_W = 22;
    localparam int PTR_SPACE_BIT = 21; // selects identification/configuration space
    localparam int PTR_LOW_W = 21; // byte-in-program-memory field
    localparam int HOLD_SEL_W = 3; // holding register select
    localparam int HOLD_COUNT = 8;
    localparam int PROG_BLOCK_LSB = 3; // 8-byte program block
    localparam int ERASE_BLOCK_LSB = 6; // 64-byte erase block
    localparam int UPPER_BYTE_W = 6; // implemented bits of the upper pointer byte

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [PTR_W-1:0] PTR_RESET = 22'h000000;
    localparam logic [7:0] LATCH_RESET = 8'h00;
    localparam logic [7:0] HOLD_RESET = 8'hff;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_PERIOD_PS = 4000;
    localparam longint PROG_TIME_NS = 2000000; // internal programming timer period
    localparam longint PROG_CYCLES_DEF = (PROG_TIME_NS * 1000) / CLK_PERIOD_PS;

    // ************************************************************
    // table operation forms and bus answers
    // ************************************************************
    typedef enum logic [1:0] {
        MODE_PLAIN = 2'h0,
        MODE_POST_INC = 2'h1,
        MODE_POST_DEC = 2'h2,
        MODE_PRE_INC = 2'h3
    } op_mode_t;

    localparam logic [1:0] RESP_OKAY = 2'h0;

endpackage

// [hw/table_pointer_access_unit.sv]
// table access unit: latch, 22-bit pointer, eight holding registers, long write/erase timer
// assumes core commands and program memory answers on ref_clk; registers over AXI4-Lite
//
// How it works
// - an 8-bit table latch register sits in the register space
// - upper, high and low pointer bytes join into one 22-bit byte pointer
// - the low 21 pointer bits select a byte of up to 2 Mbytes
// - pointer top bit set reaches identification and configuration space instead
// - automatic increment or decrement changes only the low 21 pointer bits
// - a table read uses all 22 pointer bits and loads the latch
// - a table write puts the latch into holding register chosen by bits 2..0
// - a long write programs the 8-byte block chosen by bits 21..3
// - an erase clears the 64-byte block chosen by bits 21..6
// - the plain form accesses and leaves the pointer unchanged
// - the post-increment form accesses, then adds one to the pointer
// - the post-decrement form accesses, then subtracts one from the pointer
// - the pre-increment form adds one first, then accesses the new address
// - unused register addresses read as zero
// - the core is stalled for the whole long cycle, ended by the timer
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps

module table_pointer_access_unit
    import table_access_pkg::*;
#(
    parameter int ADDR_W = 16,
    parameter longint PROG_CYCLES = PROG_CYCLES_DEF
) (
    input wire logic ref_clk,
    input wire logic rst,
    // register bus
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // core table operations
    input wire logic opValid,
    input wire logic opWrite,
    input wire logic [1:0] opMode,
    output logic opReady,
    output logic opDone,
    output logic [7:0] tableLatch,
    // program memory read port
    output logic memRdReq,
    output logic [PTR_W-1:0] memRdAddr,
    input wire logic [7:0] memRdData,
    input wire logic memRdValid,
    // long write and erase
    input wire logic progStart,
    input wire logic eraseStart,
    output logic progReq,
    output logic [PTR_W-PROG_BLOCK_LSB-1:0] progBlock,
    output logic [HOLD_COUNT*8-1:0] progData,
    output logic eraseReq,
    output logic [PTR_W-ERASE_BLOCK_LSB-1:0] eraseBlock,
    output logic coreStall
);

    // ************************************************************
    // elaboration checks
    // ************************************************************
    if (ADDR_W < 14 || ADDR_W > 32) begin : g_bad_addr
        $error("ADDR_W must lie between 14 and 32");
    end
    if (PROG_CYCLES < 1 || PROG_CYCLES > 64'hffff_ffff) begin : g_bad_prog
        $error("PROG_CYCLES must fit a 32-bit timer and be at least one");
    end
    // the holding select, the block size and the register count must agree
    if (HOLD_COUNT != (1 << HOLD_SEL_W) || PROG_BLOCK_LSB != HOLD_SEL_W) begin : g_bad_hold
        $error("holding registers must fill exactly one program block");
    end
    // both block fields and the upper byte must fit inside the pointer
    if (ERASE_BLOCK_LSB <= PROG_BLOCK_LSB || PTR_W != 16 + UPPER_BYTE_W
        || PTR_LOW_W != PTR_W - 1) begin : g_bad_ptr
        $error("pointer field layout is inconsistent");
    end

    localparam logic [31:0] PROG_LAST = 32'(PROG_CYCLES - 1);

    // ************************************************************
    // state
    // ************************************************************
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_READ = 3'b010,
        ST_LONG = 3'b100
    } state_t;

    typedef struct packed {
        state_t state;
        logic [PTR_W-1:0] ptr;
        logic [7:0] latch;
        logic [HOLD_COUNT-1:0][7:0] hold;
        logic [31:0] timer;
        logic awready;
        logic wready;
        logic bvalid;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] bresp;
        logic [1:0] rresp;
        logic opReady;
        logic opDone;
        logic memRdReq;
        logic [PTR_W-1:0] memRdAddr;
        logic progReq;
        logic [PTR_W-PROG_BLOCK_LSB-1:0] progBlock;
        logic eraseReq;
        logic [PTR_W-ERASE_BLOCK_LSB-1:0] eraseBlock;
        logic stall;
    } unit_state_t;

    unit_state_t s_q;
    unit_state_t s_d;

    // ************************************************************
    // next-state logic
    // ************************************************************
    // bus write: valids seen in idle, both readies pulse next cycle, bvalid the cycle after
    // bus read: arready pulses, then rvalid and rdata stand until rready
    // table op: taken on opValid with opReady; the pointer moves at that same edge
    // table read: memory request next cycle, latch and opDone once memory answers
    // long cycle: start seen in idle, request and stall next cycle, timer ends it
    // only one of op, bus write and long start may begin in any idle cycle

    logic [ADDR_W-3:0] wrWord;
    logic [ADDR_W-3:0] rdWord;
    logic [PTR_W-1:0] ptrInc;
    logic [PTR_W-1:0] ptrDec;
    logic [PTR_W-1:0] accAddr;
    logic opTake;
    logic wrStart;
    logic wrDo;
    logic longStart;

    // increment and decrement wrap inside the low field; the space bit rides along
    assign ptrInc = {s_q.ptr[PTR_SPACE_BIT], s_q.ptr[PTR_LOW_W-1:0] + 21'h000001};
    assign ptrDec = {s_q.ptr[PTR_SPACE_BIT], s_q.ptr[PTR_LOW_W-1:0] - 21'h000001};
    // pre-increment accesses the updated address, every other form the current one
    assign accAddr = (opMode == MODE_PRE_INC) ? ptrInc : s_q.ptr;
    assign wrWord = s_axi_awaddr[ADDR_W-1:BYTE_ADDR_SHIFT];
    assign rdWord = s_axi_araddr[ADDR_W-1:BYTE_ADDR_SHIFT];

    // a command and a bus write never start in the same idle cycle: the command wins
    assign opTake = opValid && s_q.opReady;
    // a long start also beats a bus write, so no pointer write can land mid-cycle
    assign wrStart = (s_q.state == ST_IDLE) && !opTake && s_axi_awvalid && s_axi_wvalid
        && !s_q.awready && !s_q.bvalid
        && !longStart;
    assign wrDo = s_q.awready && s_axi_awvalid && s_axi_wvalid;
    assign longStart = (s_q.state == ST_IDLE) && !opTake && !s_q.awready
        && (progStart || eraseStart);

    always_comb begin
        s_d = s_q;
        // pulses default low every cycle
        s_d.opDone = 1'b0;
        s_d.memRdReq = 1'b0;
        s_d.progReq = 1'b0;
        s_d.eraseReq = 1'b0;
        s_d.awready = wrStart;
        s_d.wready = wrStart;

        // register write through the bus, low byte lane only
        if (wrDo) begin
            s_d.bvalid = 1'b1;
            s_d.bresp = RESP_OKAY; // unmapped writes still answer okay
            if (s_axi_wstrb[0]) begin
                case (wrWord)
                    (ADDR_W-2)'(IDX_TABLE_LATCH): s_d.latch = s_axi_wdata[7:0];
                    (ADDR_W-2)'(IDX_POINTER_LOW): s_d.ptr[7:0] = s_axi_wdata[7:0];
                    (ADDR_W-2)'(IDX_POINTER_HIGH): s_d.ptr[15:8] = s_axi_wdata[7:0];
                    (ADDR_W-2)'(IDX_POINTER_UPPER): begin
                        s_d.ptr[PTR_W-1:16] = s_axi_wdata[UPPER_BYTE_W-1:0];
                    end
                    default: ; // unmapped writes are dropped
                endcase
            end
        end
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end

        // register read; the answer is built one cycle after the address is taken
        s_d.arready = s_axi_arvalid && !s_q.arready && !s_q.rvalid;
        if (s_q.arready && s_axi_arvalid) begin
            s_d.rvalid = 1'b1;
            s_d.rresp = RESP_OKAY;
            case (rdWord)
                (ADDR_W-2)'(IDX_TABLE_LATCH): s_d.rdata = {24'h000000, s_q.latch};
                (ADDR_W-2)'(IDX_POINTER_LOW): s_d.rdata = {24'h000000, s_q.ptr[7:0]};
                (ADDR_W-2)'(IDX_POINTER_HIGH): s_d.rdata = {24'h000000, s_q.ptr[15:8]};
                (ADDR_W-2)'(IDX_POINTER_UPPER): begin
                    s_d.rdata = {26'h0000000, s_q.ptr[PTR_W-1:16]};
                end
                default: s_d.rdata = 32'h00000000;
            endcase
        end
        if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end

        // table operations and the long cycle
        case (s_q.state)
            ST_IDLE: begin
                if (opTake) begin
                    // pointer update happens once, at the moment the command is taken
                    case (opMode)
                        MODE_POST_INC: s_d.ptr = ptrInc;
                        MODE_POST_DEC: s_d.ptr = ptrDec;
                        MODE_PRE_INC: s_d.ptr = ptrInc;
                        default: s_d.ptr = s_q.ptr;
                    endcase
                    // short write: only a holding register changes, memory is untouched
                    if (opWrite) begin
                        s_d.hold[accAddr[HOLD_SEL_W-1:0]] = s_q.latch;
                        s_d.opDone = 1'b1;
                    end else begin
                        // the space bit goes out with the address to reach id/config bytes
                        s_d.memRdReq = 1'b1;
                        s_d.memRdAddr = accAddr;
                        s_d.state = ST_READ;
                    end
                end else if (longStart) begin
                    s_d.state = ST_LONG;
                    s_d.stall = 1'b1;
                    s_d.timer = 32'h00000000;
                    if (progStart) begin
                        // program wins when both starts arrive together
                        s_d.progReq = 1'b1;
                        s_d.progBlock = s_q.ptr[PTR_W-1:PROG_BLOCK_LSB];
                    end else begin
                        s_d.eraseReq = 1'b1;
                        s_d.eraseBlock = s_q.ptr[PTR_W-1:ERASE_BLOCK_LSB];
                    end
                end
            end
            ST_READ: begin
                // the latch takes the byte only when memory answers
                if (memRdValid) begin
                    s_d.latch = memRdData;
                    s_d.opDone = 1'b1;
                    s_d.state = ST_IDLE;
                end
            end
            ST_LONG: begin
                // the programming timer alone ends the cycle
                if (s_q.timer == PROG_LAST) begin
                    s_d.stall = 1'b0;
                    s_d.state = ST_IDLE;
                end else begin
                    s_d.timer = s_q.timer + 32'h00000001;
                end
            end
            default: begin
                // an illegal state code returns to idle and releases the core
                s_d.state = ST_IDLE;
                s_d.stall = 1'b0;
            end
        endcase

        // ready is offered only in an idle cycle with no bus write near
        s_d.opReady = (s_d.state == ST_IDLE) && !s_d.awready && !wrDo && !s_d.stall
            && !(s_q.state == ST_IDLE && opTake);
    end

    // ************************************************************
    // state register
    // ************************************************************
    // synchronous reset; every field takes a constant
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_q.state <= ST_IDLE;
            s_q.ptr <= PTR_RESET;
            s_q.latch <= LATCH_RESET;
            // holding registers start at the erased value
            s_q.hold <= {HOLD_COUNT{HOLD_RESET}};
            s_q.timer <= 32'h00000000;
            s_q.awready <= 1'b0;
            s_q.wready <= 1'b0;
            s_q.bvalid <= 1'b0;
            s_q.arready <= 1'b0;
            s_q.rvalid <= 1'b0;
            s_q.rdata <= 32'h00000000;
            s_q.bresp <= RESP_OKAY;
            s_q.rresp <= RESP_OKAY;
            s_q.opReady <= 1'b0;
            s_q.opDone <= 1'b0;
            s_q.memRdReq <= 1'b0;
            s_q.memRdAddr <= PTR_RESET;
            s_q.progReq <= 1'b0;
            s_q.progBlock <= '0;
            s_q.eraseReq <= 1'b0;
            s_q.eraseBlock <= '0;
            s_q.stall <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    // ************************************************************
    // outputs, all straight from the state register
    // ************************************************************
    assign s_axi_awready = s_q.awready;
    assign s_axi_wready = s_q.wready;
    assign s_axi_bvalid = s_q.bvalid;
    // responses are registered too, so every port leaves a flip-flop
    assign s_axi_bresp = s_q.bresp;
    assign s_axi_arready = s_q.arready;
    assign s_axi_rvalid = s_q.rvalid;
    assign s_axi_rdata = s_q.rdata;
    assign s_axi_rresp = s_q.rresp;
    assign opReady = s_q.opReady;
    assign opDone = s_q.opDone;
    assign tableLatch = s_q.latch;
    assign memRdReq = s_q.memRdReq;
    assign memRdAddr = s_q.memRdAddr;
    assign progReq = s_q.progReq;
    assign progBlock = s_q.progBlock;
    // holding bytes leave as one word, register 0 in the low byte
    assign progData = s_q.hold;
    assign eraseReq = s_q.eraseReq;
    assign eraseBlock = s_q.eraseBlock;
    assign coreStall = s_q.stall;

endmodule // table_pointer_access_unit

// [dv/table_access_asserts.sv]
// checker: port relations of the table access unit
// assumes it is bound into the unit; one clock, synchronous reset
`timescale 1ns/1ps
module table_access_asserts
    import table_access_pkg::*;
#(
    parameter int ADDR_W = 16,
    parameter longint PROG_CYCLES = 10
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic opValid,
    input wire logic opWrite,
    input wire logic opReady,
    input wire logic opDone,
    input wire logic [7:0] tableLatch,
    input wire logic memRdReq,
    input wire logic memRdValid,
    input wire logic [7:0] memRdData,
    input wire logic progReq,
    input wire logic eraseReq,
    input wire logic coreStall
);
    // ********
    // helpers
    // ********
    int stallCnt_q;
    wire logic [ADDR_W-1:0] rdIdx = s_axi_araddr >> 2;
    wire logic mapped = rdIdx >= ADDR_W'(IDX_TABLE_LATCH) && rdIdx <= ADDR_W'(IDX_POINTER_UPPER);
    // stall length so far; a counter since the timer is far beyond a repetition
    always_ff @(posedge ref_clk) begin
        stallCnt_q <= (rst || !coreStall) ? 0 : stallCnt_q + 1;
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // ********
    // assertions
    // ********
    chk_read_fetch: assert property (opValid && opReady && !opWrite |=> memRdReq && !opReady)
        else $error("read taken without a memory request");
    chk_latch_load: assert property (memRdValid |=> opDone && tableLatch == $past(memRdData))
        else $error("latch not loaded from memory answer");
    chk_write_done: assert property (opValid && opReady && opWrite |=> opDone ##1 !opDone)
        else $error("table write did not complete in one cycle");
    chk_prog_stall: assert property (progReq |-> coreStall && !eraseReq)
        else $error("program request without stall");
    chk_erase_pulse: assert property ($rose(eraseReq) |-> coreStall ##1 !eraseReq)
        else $error("erase request not a single stalled pulse");
    chk_stall_len: assert property ($fell(coreStall) |-> stallCnt_q == PROG_CYCLES)
        else $error("long cycle length differs from timer");
    chk_stall_block: assert property (coreStall |-> !opReady && !memRdReq)
        else $error("core op accepted during long cycle");
    chk_unmapped_zero: assert property (s_axi_arvalid && s_axi_arready && !mapped |=>
        s_axi_rvalid && s_axi_rdata == 32'h0) else $error("unmapped read not zero");
    cover property (progReq);
    cover property (eraseReq);
    cover property (memRdValid && !opWrite);
endmodule // table_access_asserts

// [dv/program_memory_model.sv]
// program memory model: answers byte reads after a short or long wait
// assumes one read outstanding at a time, same clock as the unit
`timescale 1ns/1ps
module program_memory_model (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic slow,
    input wire logic memRdReq,
    input wire logic [21:0] memRdAddr,
    output logic [7:0] memRdData,
    output logic memRdValid
);
    logic [21:0] addr;
    logic busy;
    int left;
    // content mixes all 22 address bits, so a wrong top bit shows up
    function automatic logic [7:0] byteAt(input logic [21:0] a);
        return a[7:0] ^ a[15:8] ^ {a[21:16], 2'b01};
    endfunction
    // data toggles between answers so a stale byte is never mistaken for one
    always @(posedge ref_clk) begin
        memRdValid <= 1'b0;
        memRdData <= ~memRdData;
        if (rst) begin
            busy = 1'b0;
            memRdData <= 8'h5a;
        end else if (memRdReq) begin
            addr = memRdAddr;
            left = slow ? 3 : 0;
            busy = 1'b1;
        end else if (busy && left > 0) begin
            left--;
        end else if (busy) begin
            memRdValid <= 1'b1;
            memRdData <= byteAt(addr);
            busy = 1'b0;
        end
    end
endmodule // program_memory_model

// [dv/table_pointer_access_unit_tb.sv]
// bench: table access unit driven over the register bus and the core op port
// assumes the memory model answers reads; long cycles shortened to 10 clocks
`timescale 1ns/1ps
module table_pointer_access_unit_tb
    import table_access_pkg::*;
;
    typedef logic [82:0] val_t;
    logic ref_clk = 1'b0;
    logic rst, slow, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [15:0] s_axi_awaddr, s_axi_araddr, eraseBlock;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, opMode;
    logic opValid, opWrite, opReady, opDone, memRdReq, memRdValid;
    logic progStart, eraseStart, progReq, eraseReq, coreStall;
    logic [7:0] tableLatch, memRdData, latch;
    logic [21:0] memRdAddr, ptr;
    logic [18:0] progBlock;
    logic [63:0] progData;
    logic [7:0][7:0] hold;
    val_t rdQ[$], adQ[$], pgQ[$], ltQ[$];
    int nFail = 0, checkCount = 0, seed = 32'h861960d4, r;
    table_pointer_access_unit #(.PROG_CYCLES(10)) dut_u (.*);
    program_memory_model pmem_u (.*);
    always #2 ref_clk = ~ref_clk;
    // ********
    // checking and closing
    // ********
    task automatic chk(input val_t seen, input val_t exp);
        checkCount++;
        if (seen !== exp) begin
            nFail++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        if (nFail == 0 && checkCount > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // one clock of a bounded wait; a hang ends the run as a failure
    task automatic tick(inout int n);
        @(posedge ref_clk);
        n++;
        if (n > 200) begin
            nFail++;
            conclude();
        end
    endtask
    // each result seen takes the oldest note
    always @(posedge ref_clk) begin
        if (s_axi_rvalid && s_axi_rready) chk(val_t'(s_axi_rdata), rdQ.pop_front());
        if (memRdReq) chk(val_t'(memRdAddr), adQ.pop_front());
        if (progReq) chk({progBlock, progData}, pgQ.pop_front());
        if (eraseReq) chk(val_t'(eraseBlock), pgQ.pop_front());
        if (opDone) chk(val_t'(tableLatch), ltQ.pop_front());
        if (s_axi_bvalid && s_axi_bready) chk(val_t'(s_axi_bresp), val_t'(RESP_OKAY));
        if (s_axi_rvalid && s_axi_rready) chk(val_t'(s_axi_rresp), val_t'(RESP_OKAY));
        if (s_axi_wready) chk(val_t'(s_axi_awready), val_t'(1'b1));
    end
    // ********
    // bus and core drivers
    // ********
    task automatic axiWr(input logic [11:0] idx, input logic [7:0] d);
        int n = 0;
        bit awDone = 1'b0;
        bit wDone = 1'b0;
        s_axi_awaddr <= {2'b00, idx, 2'b00};
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        // each channel is released at the edge that takes it
        do begin
            tick(n);
            awDone |= s_axi_awready;
            wDone |= s_axi_wready;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!(awDone && wDone));
        do tick(n); while (!s_axi_bvalid);
    endtask
    task automatic axiRd(input logic [11:0] idx, input logic [7:0] exp);
        int n = 0;
        rdQ.push_back(val_t'(exp));
        s_axi_araddr <= {2'b00, idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        do tick(n); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do tick(n); while (!s_axi_rvalid);
    endtask
    task automatic setPtr(input logic [21:0] p);
        axiWr(IDX_POINTER_LOW, p[7:0]);
        axiWr(IDX_POINTER_HIGH, p[15:8]);
        axiWr(IDX_POINTER_UPPER, {2'b11, p[21:16]});
        ptr = p;
    endtask
    task automatic setLatch(input logic [7:0] d);
        axiWr(IDX_TABLE_LATCH, d);
        latch = d;
    endtask
    task automatic readBack();
        axiRd(IDX_TABLE_LATCH, latch);
        axiRd(IDX_POINTER_LOW, ptr[7:0]);
        axiRd(IDX_POINTER_HIGH, ptr[15:8]);
        axiRd(IDX_POINTER_UPPER, {2'b00, ptr[21:16]});
    endtask
    // steps wrap inside the low field and never touch the top bit
    function automatic logic [21:0] bump(input logic [21:0] p, input logic up);
        return {p[21], up ? p[20:0] + 21'h1 : p[20:0] - 21'h1};
    endfunction
    task automatic op(input logic w, input op_mode_t m);
        logic [21:0] acc;
        int n = 0;
        acc = (m == MODE_PRE_INC) ? bump(ptr, 1'b1) : ptr;
        if (m == MODE_POST_INC || m == MODE_PRE_INC) ptr = bump(ptr, 1'b1);
        if (m == MODE_POST_DEC) ptr = bump(ptr, 1'b0);
        if (w) hold[acc[2:0]] = latch;
        else adQ.push_back(val_t'(acc));
        if (!w) latch = pmem_u.byteAt(acc);
        ltQ.push_back(val_t'(latch));
        opValid <= 1'b1;
        opWrite <= w;
        opMode <= m;
        do tick(n); while (!opReady);
        opValid <= 1'b0;
        do tick(n); while (!opDone);
        readBack();
    endtask
    // start is held until the stall shows, then dropped so it cannot retrigger
    task automatic longRun(input logic prog);
        int n = 0;
        if (prog) progStart <= 1'b1;
        else eraseStart <= 1'b1;
        do tick(n); while (!coreStall);
        progStart <= 1'b0;
        eraseStart <= 1'b0;
        do tick(n); while (coreStall);
    endtask
    // ********
    // main sequence
    // ********
    initial begin
        {rst, slow, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, opValid, opWrite} <= 7'h40;
        {s_axi_bready, s_axi_rready, s_axi_wstrb} <= 6'h31;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, opMode, progStart, eraseStart} <= '0;
        latch = LATCH_RESET;
        ptr = PTR_RESET;
        hold = {8{HOLD_RESET}};
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        readBack();
        axiWr(12'hff4, 8'h77);
        axiRd(12'hff4, 8'h00);
        axiRd(12'hff9, 8'h00);
        setPtr(22'h3fffff);
        op(1'b0, MODE_POST_INC);
        op(1'b0, MODE_POST_DEC);
        op(1'b0, MODE_PRE_INC);
        op(1'b0, MODE_PLAIN);
        repeat (16) begin
            r = $random(seed);
            slow <= r[31];
            setPtr(r[21:0]);
            setLatch(r[29:22]);
            op(r[30], op_mode_t'(r[23:22]));
        end
        r = $random(seed);
        setPtr({r[21:3], 3'h0});
        for (int i = 0; i < 8; i++) begin
            setLatch(8'(i * 37 + r[31:24]));
            op(1'b1, MODE_POST_INC);
        end
        pgQ.push_back({ptr[21:3], hold});
        longRun(1'b1);
        pgQ.push_back(val_t'(ptr[21:6]));
        longRun(1'b0);
        chk(val_t'(rdQ.size() + adQ.size() + ltQ.size()), '0);
        chk(val_t'(pgQ.size()), '0);
        conclude();
    end
endmodule // table_pointer_access_unit_tb
bind table_pointer_access_unit table_access_asserts #(.ADDR_W(ADDR_W), .PROG_CYCLES(PROG_CYCLES))
    chk_u (.*);
